// >>> src/asc_pkg.sv
// Shared constants and types for both ends of the serial controller register link.
package asc_pkg;
  // ----------------------------------------
  // Device register addresses and fields
  // ----------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_DIV_LO = 3'h3;
  localparam logic [2:0] REG_CTRL_DIV_HI = 3'h4;
  localparam logic [2:0] REG_THR_IRQ = 3'h5;
  localparam int DIV_W = 11;
  localparam int DIV_LO_W = 8;
  localparam int BIT_DSR = 7;
  localparam int BIT_FULL_RST = 6;
  localparam int BIT_TX_RST = 5;
  localparam int BIT_RX_RST = 4;
  localparam int BIT_SPEED = 3;
  localparam int TX_THR_LSB = 6;
  localparam int TX_THR_W = 2;
  localparam int RX_THR_LSB = 3;
  localparam int RX_THR_W = 3;
  localparam int BIT_ERR_EN = 2;
  localparam int BIT_HS_EN = 1;
  localparam int BIT_BRK_EN = 0;
  localparam logic [1:0] RDBACK_ONES = 2'h3;
  // ----------------------------------------
  // Thresholds, depths and cycle counts
  // ----------------------------------------
  localparam logic [1:0] TX_THR_EMPTY = 2'h0;
  localparam logic [2:0] RX_THR_SPEED = 3'h0;
  localparam logic [2:0] RX_THR_RESET = 3'h1;
  localparam logic [2:0] RX_THR_TEST = 3'h7;
  localparam logic [2:0] TX_DEPTH = 3'h4;
  localparam logic [2:0] RX_DEPTH = 3'h6;
  localparam logic [2:0] SOFT_RST_CYCLES = 3'h4;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  // ----------------------------------------
  // Host bridge registers
  // ----------------------------------------
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_CTRL = 4'h8;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [2:0] HOST_GAP = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_ADDR = 3'h1,
    HST_WRITE = 3'h2,
    HST_READ1 = 3'h3,
    HST_READ2 = 3'h4,
    HST_GAP = 3'h5
  } asc_phase_t;
endpackage

// >>> src/asc_bus_if.sv
// Multiplexed byte bus between host bridge and serial controller.
interface asc_bus_if;
  logic [7:0] bus_h_out;
  logic bus_h_oe;
  logic [7:0] bus_d_out;
  logic bus_d_oe;
  logic [7:0] host_addr_data_bus;
  logic addr_latch;
  logic write_n;
  logic read_n;
  logic reset_pin;
  // The bus floats high when nobody drives it.
  assign host_addr_data_bus = bus_h_oe ? bus_h_out : (bus_d_oe ? bus_d_out : 8'hFF);
  modport device (input host_addr_data_bus, addr_latch, write_n, read_n, reset_pin,
                  output bus_d_out, bus_d_oe);
  modport host (input host_addr_data_bus,
                output bus_h_out, bus_h_oe, addr_latch, write_n, read_n, reset_pin);
endinterface

// >>> src/asc_device_end.sv
// Serial controller register end: divisor, resets, speed match and interrupt selection.
// Operation
// - Divisor low byte at 03, reset zero.
// - Register 04 bit 7 drives data-set-ready.
// - Software full reset acts like reset pin.
// - Full reset lasts four clocks, then self-clears.
// - Reset pin high clears the full-reset bit.
// - Transmitter reset clears transmit state, self-clears.
// - Receiver reset clears receive state, self-clears.
// - Speed-match flag cleared by start-bit fall.
// - Speed-match interrupt latched until written zero.
// - Register 04 bits 2..0 hold divisor 10..8.
// - Transmit threshold selects free-space interrupt condition.
// - Receive threshold one to six bytes available.
// - Receive code 000 interrupts after speed-match start.
// - Host never programs receive threshold 111.
// - Error enable: parity, framing, overrun interrupt receive.
// - Overrun when full queue takes another byte.
// - Handshake enable: falling request in circuit mode.
// - Break enable: break drives receive interrupt.
// - Ten or more low bits is break.
// - Baud tick divides clock by divisor plus one.
// - Circuit mode: select zero, handshake enabled.
// - Global enable gates pins, not status bits.
//
// The AXI4-Lite register port was decided locally.
module asc_device_end import asc_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Host bus
  asc_bus_if.device bus,
  // Datapath status
  input wire logic [2:0] tx_free_bytes,
  input wire logic [2:0] rx_avail_bytes,
  input wire logic rx_byte_stored,
  input wire logic parity_err,
  input wire logic frame_err,
  input wire logic tx_idle,
  input wire logic shift_busy,
  input wire logic rx_sample_tick,
  input wire logic rx_line,
  input wire logic start_bit_fall,
  input wire logic start_bit_end,
  // Modem lines and mode bits
  input wire logic rts_n,
  input wire logic dtr,
  input wire logic hw_handshake_enable,
  input wire logic terminal_circuit_select,
  input wire logic global_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic rx_irq_enable,
  // Control outputs
  output logic baud_tick_16x,
  output logic dsr,
  output logic core_soft_reset,
  output logic transmitter_soft_reset,
  output logic receiver_soft_reset,
  output logic speed_match_flag,
  output logic break_detected,
  output logic rx_overrun,
  // Interrupts
  output logic transmit_irq_n,
  output logic receive_irq_n
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic dsr;
    logic full_rst;
    logic [2:0] full_cnt;
    logic tx_rst;
    logic [2:0] tx_cnt;
    logic rx_rst;
    logic [2:0] rx_cnt;
    logic sm_flag;
    logic sm_armed;
    logic sm_latch;
    logic [TX_THR_W-1:0] tx_thr;
    logic [RX_THR_W-1:0] rx_thr;
    logic err_en;
    logic hs_en;
    logic brk_en;
    logic [2:0] addr;
    logic [7:0] dout;
    logic doe;
    logic [DIV_W-1:0] baud_cnt;
    logic baud_tick;
    logic [3:0] brk_cnt;
    logic brk_det;
    logic overrun;
    logic rts_prev;
    logic rts_evt;
    logic txs_n;
    logic rxs_n;
    logic txi_n;
    logic rxi_n;
  } asc_dev_st_t;

  localparam asc_dev_st_t ST_RST = '{dsr: 1'h1, rx_thr: RX_THR_RESET, rts_prev: 1'h1,
                                     txs_n: 1'h1, rxs_n: 1'h1, txi_n: 1'h1, rxi_n: 1'h1,
                                     default: '0};

  // ----
  // Threshold decoders
  // ----
  function automatic logic tx_thr_hit(input logic [1:0] thr, input logic [2:0] free);
    if (thr == TX_THR_EMPTY) begin
      tx_thr_hit = (free == TX_DEPTH);
    end else begin
      // Code 01 wants three free, 10 two and 11 one.
      tx_thr_hit = ({1'b0, free} + {2'b00, thr}) >= {1'b0, TX_DEPTH};
    end
  endfunction

  function automatic logic rx_thr_hit(input logic [2:0] thr, input logic [2:0] avail,
                                      input logic latch);
    if (thr == RX_THR_SPEED) begin
      rx_thr_hit = latch;
    end else if (thr == RX_THR_TEST) begin
      rx_thr_hit = 1'b0;
    end else begin
      rx_thr_hit = avail >= thr;
    end
  endfunction

  // ----
  // State update
  // ----
  asc_dev_st_t st;
  asc_dev_st_t next_st;
  logic dce_mode;
  logic tx_cond;
  logic rx_cond;
  logic [7:0] din;

  assign din = bus.host_addr_data_bus;
  assign dce_mode = !terminal_circuit_select && hw_handshake_enable;
  assign tx_cond = tx_thr_hit(st.tx_thr, tx_free_bytes) || (st.hs_en && st.rts_evt);
  assign rx_cond = rx_thr_hit(st.rx_thr, rx_avail_bytes, st.sm_latch)
                   || (st.err_en && (parity_err || frame_err || st.overrun))
                   || (st.brk_en && st.brk_det);

  always_comb begin
    next_st = st;
    if (st.full_rst) begin
      // Internal reset keeps the latched address so reads still work; address latches and writes seen during it are ignored.
      next_st = ST_RST;
      next_st.addr = st.addr;
      next_st.full_cnt = st.full_cnt - 3'h1;
      next_st.full_rst = (st.full_cnt != 3'h1);
    end else begin
      if (st.tx_rst) begin
        next_st.tx_cnt = st.tx_cnt - 3'h1;
        next_st.tx_rst = (st.tx_cnt != 3'h1);
        next_st.rts_evt = 1'b0;
      end
      if (st.rx_rst) begin
        next_st.rx_cnt = st.rx_cnt - 3'h1;
        next_st.rx_rst = (st.rx_cnt != 3'h1);
        next_st.overrun = 1'b0;
        next_st.brk_cnt = '0;
        next_st.brk_det = 1'b0;
      end
      if (st.div != '0 && st.baud_cnt >= st.div) begin
        next_st.baud_cnt = '0;
        next_st.baud_tick = 1'b1;
      end else begin
        next_st.baud_cnt = (st.div == '0) ? '0 : st.baud_cnt + 11'h001;
        next_st.baud_tick = 1'b0;
      end
      if (bus.addr_latch) begin
        next_st.addr = din[2:0];
      end
      if (!bus.write_n) begin
        case (st.addr)
          REG_DIV_LO: begin
            next_st.div[DIV_LO_W-1:0] = din;
          end
          REG_CTRL_DIV_HI: begin
            next_st.dsr = din[BIT_DSR];
            next_st.div[DIV_W-1:DIV_LO_W] = din[DIV_W-DIV_LO_W-1:0];
            if (din[BIT_FULL_RST]) begin
              next_st.full_rst = 1'b1;
              next_st.full_cnt = SOFT_RST_CYCLES;
            end
            if (din[BIT_TX_RST]) begin
              next_st.tx_rst = 1'b1;
              next_st.tx_cnt = SOFT_RST_CYCLES;
            end
            if (din[BIT_RX_RST]) begin
              next_st.rx_rst = 1'b1;
              next_st.rx_cnt = SOFT_RST_CYCLES;
            end
            if (din[BIT_SPEED]) begin
              next_st.sm_flag = 1'b1;
            end else begin
              next_st.sm_latch = 1'b0;
            end
          end
          REG_THR_IRQ: begin
            next_st.tx_thr = din[TX_THR_LSB +: TX_THR_W];
            next_st.rx_thr = din[RX_THR_LSB +: RX_THR_W];
            next_st.err_en = din[BIT_ERR_EN];
            next_st.hs_en = din[BIT_HS_EN];
            next_st.brk_en = din[BIT_BRK_EN];
          end
          default: begin
          end
        endcase
      end
      // Hardware events are applied after writes so a set is never lost to a clear.
      if (rx_sample_tick) begin
        if (!rx_line) begin
          if (st.brk_cnt != BREAK_BITS) begin
            next_st.brk_cnt = st.brk_cnt + 4'h1;
          end
          if (st.brk_cnt >= BREAK_BITS - 4'h1) begin
            next_st.brk_det = 1'b1;
          end
        end else begin
          next_st.brk_cnt = '0;
          next_st.brk_det = 1'b0;
        end
      end
      if (rx_byte_stored && rx_avail_bytes == RX_DEPTH) begin
        next_st.overrun = 1'b1;
      end
      next_st.rts_prev = rts_n;
      if (dce_mode && st.rts_prev && !rts_n) begin
        next_st.rts_evt = 1'b1;
      end else if (rts_n) begin
        next_st.rts_evt = 1'b0;
      end
      if (st.sm_flag && start_bit_fall) begin
        next_st.sm_flag = 1'b0;
        next_st.sm_armed = 1'b1;
      end
      if (st.sm_armed && start_bit_end) begin
        next_st.sm_armed = 1'b0;
        next_st.sm_latch = 1'b1;
      end
      next_st.txs_n = !(tx_irq_enable && tx_cond);
      next_st.rxs_n = !(rx_irq_enable && rx_cond);
      next_st.txi_n = !(global_irq_enable && tx_irq_enable && tx_cond);
      next_st.rxi_n = !(global_irq_enable && rx_irq_enable && rx_cond);
    end
    // Read data is driven one cycle after the read strobe is seen.
    next_st.doe = !bus.read_n;
    case (st.addr)
      REG_STATUS: next_st.dout = {st.brk_det, !rts_n, st.rxs_n, st.txs_n, st.overrun,
                                  tx_idle, frame_err, parity_err};
      REG_DIV_LO: next_st.dout = st.div[DIV_LO_W-1:0];
      REG_CTRL_DIV_HI: next_st.dout = {dtr, shift_busy, RDBACK_ONES, st.sm_flag,
                                       st.div[DIV_W-1:DIV_LO_W]};
      default: next_st.dout = 8'h00;
    endcase
    if (bus.reset_pin) begin
      next_st = ST_RST;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----
  // Outputs
  // ----
  assign bus.bus_d_out = st.dout;
  assign bus.bus_d_oe = st.doe;
  assign baud_tick_16x = st.baud_tick;
  assign dsr = st.dsr;
  assign core_soft_reset = st.full_rst;
  assign transmitter_soft_reset = st.tx_rst;
  assign receiver_soft_reset = st.rx_rst;
  assign speed_match_flag = st.sm_flag;
  assign break_detected = st.brk_det;
  assign rx_overrun = st.overrun;
  assign transmit_irq_n = st.txi_n;
  assign receive_irq_n = st.rxi_n;
endmodule

// >>> src/asc_host_end.sv
// Host bridge: AXI4-Lite registers in, multiplexed byte bus cycles out.
module asc_host_end import asc_pkg::*; #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device bus
  asc_bus_if.host bus
);
  typedef struct packed {
    asc_phase_t phase;
    logic is_read;
    logic [2:0] addr;
    logic [7:0] data;
    logic [2:0] gap;
    logic [7:0] rdata;
    logic rst_pin;
    logic [7:0] ad_out;
    logic ad_oe;
    logic ale;
    logic write_n;
    logic read_n;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } asc_host_st_t;

  localparam asc_host_st_t ST_RST = '{phase: HST_IDLE, write_n: 1'h1, read_n: 1'h1,
                                      default: '0};

  asc_host_st_t st;
  asc_host_st_t next_st;
  logic aw_take;
  logic ar_take;

  assign aw_take = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
  assign ar_take = s_axi_arvalid && !st.rvalid;

  always_comb begin
    next_st = st;
    if (s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    case (st.phase)
      HST_ADDR: begin
        next_st.ale = 1'b0;
        if (st.is_read) begin
          next_st.ad_oe = 1'b0;
          next_st.read_n = 1'b0;
          next_st.phase = HST_READ1;
        end else begin
          next_st.ad_out = st.data;
          next_st.write_n = 1'b0;
          next_st.phase = HST_WRITE;
        end
      end
      HST_WRITE: begin
        next_st.write_n = 1'b1;
        next_st.ad_oe = 1'b0;
        next_st.gap = HOST_GAP;
        next_st.phase = HST_GAP;
      end
      HST_READ1: begin
        next_st.phase = HST_READ2;
      end
      HST_READ2: begin
        next_st.rdata = bus.host_addr_data_bus;
        next_st.read_n = 1'b1;
        next_st.gap = HOST_GAP;
        next_st.phase = HST_GAP;
      end
      HST_GAP: begin
        // The gap also lets the device release the bus and finish self-clearing resets.
        next_st.gap = st.gap - 3'h1;
        if (st.gap == 3'h1) begin
          next_st.phase = HST_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (aw_take) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (s_axi_awaddr)
        HREG_CMD: begin
          if (st.phase != HST_IDLE) begin
            next_st.bresp = RESP_SLVERR;
          end else if (!s_axi_wdata[CMD_READ_BIT]
                       && s_axi_wdata[CMD_ADDR_LSB +: 3] == REG_THR_IRQ
                       && s_axi_wdata[RX_THR_LSB +: RX_THR_W] == RX_THR_TEST) begin
            next_st.bresp = RESP_SLVERR;
          end else begin
            next_st.is_read = s_axi_wdata[CMD_READ_BIT];
            next_st.addr = s_axi_wdata[CMD_ADDR_LSB +: 3];
            next_st.data = s_axi_wdata[7:0];
            next_st.ad_out = {5'h00, s_axi_wdata[CMD_ADDR_LSB +: 3]};
            next_st.ad_oe = 1'b1;
            next_st.ale = 1'b1;
            next_st.phase = HST_ADDR;
          end
        end
        HREG_CTRL: begin
          if (s_axi_wstrb[0]) begin
            next_st.rst_pin = s_axi_wdata[0];
          end
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdat = '0;
      case (s_axi_araddr)
        HREG_STATUS: begin
          next_st.rdat[0] = (st.phase != HST_IDLE);
          next_st.rdat[STAT_DATA_LSB +: 8] = st.rdata;
        end
        HREG_CTRL: next_st.rdat[0] = st.rst_pin;
        HREG_CMD: begin
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = aw_take;
  assign s_axi_wready = aw_take;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdat;
  assign s_axi_rresp = st.rresp;
  assign bus.bus_h_out = st.ad_out;
  assign bus.bus_h_oe = st.ad_oe;
  assign bus.addr_latch = st.ale;
  assign bus.write_n = st.write_n;
  assign bus.read_n = st.read_n;
  assign bus.reset_pin = st.rst_pin;
endmodule

// >>> test/asc_bus_sva.sv
// Checker for the multiplexed byte bus between the two ends.
module asc_bus_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Byte bus
  input wire logic [7:0] bus_h_out,
  input wire logic bus_h_oe,
  input wire logic [7:0] bus_d_out,
  input wire logic bus_d_oe,
  input wire logic [7:0] host_addr_data_bus,
  input wire logic addr_latch,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ----
  // Assertions
  // ----
  AST_ALE_ONE: assert property (addr_latch |=> !addr_latch)
    else $error("latch too long");
  AST_ALE_DRIVE: assert property (addr_latch |-> bus_h_oe && host_addr_data_bus == bus_h_out)
    else $error("address not driven");
  AST_ALE_NEXT: assert property (addr_latch |=> (write_n != read_n))
    else $error("no strobe after address");
  AST_WR_ONE: assert property (!write_n |=> write_n && !bus_h_oe)
    else $error("write strobe not one cycle");
  AST_WR_GAP: assert property ($rose(write_n) |-> !addr_latch [*4])
    else $error("write gap too short");
  AST_RD_TWO: assert property ($fell(read_n) && !reset_pin |->
    !bus_h_oe ##1 (!read_n && bus_d_oe) ##1 read_n)
    else $error("read cycle shape wrong");
  AST_RD_RELEASE: assert property ($rose(read_n) |=> !bus_d_oe)
    else $error("device kept bus after read");
  AST_DATA_WIRE: assert property (bus_d_oe |-> !bus_h_oe && host_addr_data_bus == bus_d_out)
    else $error("bus contention");
  AST_PIN_QUIET: assert property (reset_pin ##1 reset_pin |-> !bus_d_oe)
    else $error("device drives bus in reset");
  COV_WRITE: cover property (addr_latch ##1 !write_n);
  COV_READ: cover property (!read_n && bus_d_oe);
  COV_PIN: cover property (reset_pin ##1 reset_pin);
endmodule

// >>> test/tb_top.sv
// Self-checking bench: AXI4-Lite host end joined to the device end.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top import asc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Signals
  // ----
  logic core_clk, resetn;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] tx_free_bytes, rx_avail_bytes;
  logic rx_byte_stored, parity_err, frame_err, tx_idle, shift_busy, rx_sample_tick, rx_line;
  logic start_bit_fall, start_bit_end, rts_n, dtr, hw_handshake_enable, terminal_circuit_select;
  logic global_irq_enable, tx_irq_enable, rx_irq_enable, baud_tick_16x, dsr, core_soft_reset;
  logic transmitter_soft_reset, receiver_soft_reset, speed_match_flag, break_detected;
  logic rx_overrun, transmit_irq_n, receive_irq_n;
  int fail_count = 0, samples_checked = 0, seed = 5, cyc = 0, c0;
  int n_core = 0, n_tx = 0, n_rx = 0;
  logic [10:0] dv;
  logic [33:0] exp_v, exp_q[$];
  asc_bus_if bus();
  asc_host_end #(.ADDR_W(4)) u_asc_host_end (
    .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus(bus.host)
  );
  asc_device_end u_asc_device_end (
    .core_clk, .resetn, .bus(bus.device), .tx_free_bytes, .rx_avail_bytes, .rx_byte_stored,
    .parity_err, .frame_err, .tx_idle, .shift_busy, .rx_sample_tick, .rx_line, .start_bit_fall,
    .start_bit_end, .rts_n, .dtr, .hw_handshake_enable, .terminal_circuit_select,
    .global_irq_enable, .tx_irq_enable, .rx_irq_enable, .baud_tick_16x, .dsr, .core_soft_reset,
    .transmitter_soft_reset, .receiver_soft_reset, .speed_match_flag, .break_detected,
    .rx_overrun, .transmit_irq_n, .receive_irq_n
  );
  asc_bus_sva u_asc_bus_sva (
    .core_clk, .resetn, .bus_h_out(bus.bus_h_out), .bus_h_oe(bus.bus_h_oe),
    .bus_d_out(bus.bus_d_out), .bus_d_oe(bus.bus_d_oe),
    .host_addr_data_bus(bus.host_addr_data_bus), .addr_latch(bus.addr_latch),
    .write_n(bus.write_n), .read_n(bus.read_n), .reset_pin(bus.reset_pin)
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (core_soft_reset) n_core <= n_core + 1;
    if (transmitter_soft_reset) n_tx <= n_tx + 1;
    if (receiver_soft_reset) n_rx <= n_rx + 1;
  end
  // Each result takes the oldest note.
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      exp_v = exp_q.pop_front();
      `CHK({s_axi_bresp, 32'h0}, exp_v)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      exp_v = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata & 32'h0000_FF01}, exp_v)
    end
  end
  // ----
  // Bus tasks
  // ----
  // Ready is looked at on the falling edge, so the release lands on the edge that took it.
  task automatic aw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(negedge core_clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge core_clk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(negedge core_clk); while (!s_axi_bvalid);
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic ar(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge core_clk); while (!s_axi_arready);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk); while (!s_axi_rvalid);
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // A write byte cycle ends six clocks, a read seven, after the command is taken.
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    aw(HREG_CMD, {15'h0, 1'b0, 5'h0, a, d}, RESP_OKAY);
    w(8);
  endtask
  task automatic dr(input logic [2:0] a, input logic [7:0] e);
    aw(HREG_CMD, {15'h0, 1'b1, 5'h0, a, 8'h00}, RESP_OKAY);
    w(8);
    ar(HREG_STATUS, {RESP_OKAY, 16'h0, e, 8'h00});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  // The whole run needs well under ten thousand clocks.
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {tx_free_bytes, rx_avail_bytes} = {3'h4, 3'h1};
    {rx_byte_stored, parity_err, frame_err, shift_busy, rx_sample_tick} = '0;
    {start_bit_fall, start_bit_end, dtr, terminal_circuit_select} = '0;
    {tx_idle, rx_line, rts_n, hw_handshake_enable} = '1;
    {global_irq_enable, tx_irq_enable, rx_irq_enable} = '1;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    w(3);
    `CHK(receive_irq_n, 1'b0)
    `CHK(dsr, 1'b1)
    dr(REG_DIV_LO, 8'h00);
    dr(REG_CTRL_DIV_HI, 8'h30);
    $display("reset done");
    dv = 11'($random(seed));
    if (dv == 11'h0) dv = 11'h1;
    dtr <= 1'($random(seed));
    shift_busy <= 1'($random(seed));
    dw(REG_DIV_LO, dv[7:0]);
    dw(REG_CTRL_DIV_HI, {5'h0, dv[10:8]});
    dr(REG_DIV_LO, dv[7:0]);
    dr(REG_CTRL_DIV_HI, {dtr, shift_busy, 3'h6, dv[10:8]});
    `CHK(dsr, 1'b0)
    @(posedge core_clk iff baud_tick_16x);
    c0 = cyc;
    @(posedge core_clk iff baud_tick_16x);
    `CHK(cyc - c0, 32'(dv) + 1)
    $display("divisor done");
    for (int t = 0; t < 4; t++) begin
      dw(REG_THR_IRQ, {2'(t), 6'h30});
      for (int f = 0; f <= 4; f++) begin
        tx_free_bytes <= 3'(f);
        w(3);
        `CHK(transmit_irq_n, !((t == 0) ? (f == 4) : (f >= 4 - t)))
      end
    end
    global_irq_enable <= 1'b0;
    w(3);
    `CHK(transmit_irq_n, 1'b1)
    dr(REG_STATUS, 8'h24);
    global_irq_enable <= 1'b1;
    tx_free_bytes <= 3'h0;
    for (int c = 1; c < 7; c++) begin
      dw(REG_THR_IRQ, {2'h3, 3'(c), 3'h0});
      for (int a = 0; a < 7; a++) begin
        rx_avail_bytes <= 3'(a);
        w(3);
        `CHK(receive_irq_n, !(a >= c))
      end
    end
    $display("thresholds done");
    rx_avail_bytes <= 3'h0;
    dw(REG_THR_IRQ, 8'hF4);
    for (int i = 0; i < 2; i++) begin
      {parity_err, frame_err} <= (i == 0) ? 2'h2 : 2'h1;
      w(3);
      `CHK(receive_irq_n, 1'b0)
      {parity_err, frame_err} <= 2'h0;
      w(3);
      `CHK(receive_irq_n, 1'b1)
    end
    for (int a = 5; a < 7; a++) begin
      rx_avail_bytes <= 3'(a);
      @(posedge core_clk) rx_byte_stored <= 1'b1;
      @(posedge core_clk) rx_byte_stored <= 1'b0;
      w(2);
      `CHK(rx_overrun, a == 6)
    end
    rx_avail_bytes <= 3'h0;
    w(3);
    `CHK(receive_irq_n, 1'b0)
    dw(REG_CTRL_DIV_HI, 8'h10);
    `CHK(n_rx, 4)
    `CHK(rx_overrun, 1'b0)
    `CHK(receive_irq_n, 1'b1)
    dw(REG_CTRL_DIV_HI, 8'h20);
    `CHK(n_tx, 4)
    dr(REG_DIV_LO, dv[7:0]);
    $display("errors done");
    dw(REG_THR_IRQ, 8'hF1);
    rx_line <= 1'b0;
    for (int i = 1; i < 12; i++) begin
      if (i == 11) rx_line <= 1'b1;
      @(posedge core_clk) rx_sample_tick <= 1'b1;
      @(posedge core_clk) rx_sample_tick <= 1'b0;
      w(2);
      if (i > 8) `CHK(break_detected, i == 10)
      if (i == 10) `CHK(receive_irq_n, 1'b0)
    end
    dw(REG_THR_IRQ, 8'h32);
    tx_free_bytes <= 3'h3;
    for (int m = 0; m < 2; m++) begin
      terminal_circuit_select <= 1'(m);
      rts_n <= 1'b0;
      w(3);
      `CHK(transmit_irq_n, 1'(m))
      rts_n <= 1'b1;
      w(3);
    end
    $display("break done");
    terminal_circuit_select <= 1'b0;
    dw(REG_THR_IRQ, 8'h00);
    dw(REG_CTRL_DIV_HI, 8'h08);
    `CHK(speed_match_flag, 1'b1)
    @(posedge core_clk) start_bit_fall <= 1'b1;
    @(posedge core_clk) start_bit_fall <= 1'b0;
    w(2);
    `CHK(speed_match_flag, 1'b0)
    @(posedge core_clk) start_bit_end <= 1'b1;
    @(posedge core_clk) start_bit_end <= 1'b0;
    w(10);
    `CHK(receive_irq_n, 1'b0)
    dw(REG_CTRL_DIV_HI, 8'h00);
    `CHK(receive_irq_n, 1'b1)
    $display("speed match done");
    dw(REG_DIV_LO, 8'h5A);
    dw(REG_CTRL_DIV_HI, 8'h40);
    `CHK(n_core, 4)
    `CHK(dsr, 1'b1)
    dr(REG_DIV_LO, 8'h00);
    dw(REG_DIV_LO, 8'hA5);
    dr(REG_DIV_LO, 8'hA5);
    dw(REG_CTRL_DIV_HI, 8'h00);
    aw(HREG_CTRL, 32'h1, RESP_OKAY);
    w(3);
    `CHK(dsr, 1'b1)
    dw(REG_DIV_LO, 8'h77);
    aw(HREG_CTRL, 32'h0, RESP_OKAY);
    w(2);
    dr(REG_DIV_LO, 8'h00);
    aw(4'hC, 32'h0, RESP_SLVERR);
    ar(4'hC, {RESP_SLVERR, 32'h0});
    aw(HREG_CMD, {21'h0, REG_THR_IRQ, 8'h38}, RESP_SLVERR);
    $display("resets done");
    w(4);
    final_report();
  end
endmodule
